// file: dma_transfer_mode_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dma_transfer_mode_control_tb;
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
	logic arvalid = 0, rready = 0, dma_stop_in = 0, slow = 0;
	logic [7:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rdata, sb_addr, system_bus_write_data;
	logic [3:0] wstrb = 4'hf, channel_request_in = 4'h0;
	logic awready, wready, bvalid, arready, rvalid, bus_req, bus_grant;
	logic sb_rd, sb_wr, sb_ack, mem_read_io_write_strobe;
	logic mem_write_io_read_strobe;
	logic [1:0] bresp, rresp, r;
	logic [2:0] cycle_type_outputs;
	logic [3:0] terminal_count_out, channel_active_out, exp_ch = 4'h1;
	logic [31:0] system_bus_read_data, d, src;
	logic [31:0] exp_a[$], exp_d[$];
	int num_errors = 0, samples_checked = 0, tc_seen = 0, i;
	initial forever #50 aclk = ~aclk;
	dtm_ctrl DUT (.aclk, .aresetn, .ce(1'b1), .awaddr, .awvalid, .awready,
		.wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
		.arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
		.channel_request_in, .dma_stop_in, .bus_req, .bus_grant,
		.ext_master_req(1'b0), .ext_master_ack(), .sb_addr, .sb_rd, .sb_wr,
		.system_bus_write_data, .system_bus_read_data, .sb_ack,
		.cycle_type_outputs, .mem_read_io_write_strobe,
		.mem_write_io_read_strobe, .ram_addr(), .ram_rd(), .ram_wr(),
		.ram_wdata(), .ram_rdata(system_bus_read_data),
		.channel_active_out, .terminal_count_out);
	dtm_mem PART (.aclk, .slow, .bus_req, .bus_grant, .sb_addr, .sb_ack,
		.cyc({sb_rd, sb_wr, mem_read_io_write_strobe,
		mem_write_io_read_strobe}), .rd_data(system_bus_read_data));
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e)
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		if (g !== e)
			num_errors++;
	endtask : chk
	task automatic give_verdict();
		$display("errors=%0d checks=%0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : give_verdict
	task automatic lim();
		if (i >= 3000)
		begin
			num_errors++;
			give_verdict();
		end
		@(posedge aclk);
	endtask : lim
	task automatic axw(input logic [7:0] a, input logic [31:0] v);
		awaddr <= a;
		wdata <= v;
		{awvalid, wvalid, bready} <= 3'h7;
		for (i = 0; i < 3000; i++)
		begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			if (bvalid)
				break;
		end
		bready <= 1'b0;
		chk(bresp, 2'b00);
		lim();
	endtask : axw
	task automatic axr(input logic [7:0] a);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		for (i = 0; i < 3000; i++)
		begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
			if (rvalid)
				break;
		end
		{d, r} = {rdata, rresp};
		rready <= 1'b0;
		lim();
	endtask : axr
	task automatic idle_wait();
		for (i = 0; i < 3000 && (exp_a.size() != 0 || bus_req); i++)
			@(posedge aclk);
		lim();
		repeat (3) @(posedge aclk);
	endtask : idle_wait
	always @(posedge aclk)
	begin
		tc_seen += (terminal_count_out != 4'h0);
		if (sb_rd)
			chk(cycle_type_outputs, 3'b110);
		if (sb_ack && !sb_wr && mem_read_io_write_strobe)
			chk(cycle_type_outputs, 3'b111);
		if (sb_ack)
			chk(channel_active_out, exp_ch);
		if (sb_ack && (sb_wr || mem_read_io_write_strobe))
			chk(sb_addr, exp_a.size() ? exp_a.pop_front() : 'x);
		if (sb_ack && sb_wr)
			chk(system_bus_write_data,
				exp_d.size() ? exp_d.pop_front() : 'x);
	end
	initial
	begin
		void'($urandom(32'h4868_025c));
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		axr(8'h00);
		chk(d, 32'h0000_0000);
		axr(8'h44);
		chk(r, 2'b10);
		$display("test registers done");
		src = $urandom & 32'h00ff_fffc;
		slow <= 1'($urandom);
		axw(8'h04, src);
		axw(8'h08, 32'h0000_2000);
		axw(8'h0c, 32'h0000_0002);
		for (int k = 0; k < 3; k++)
			exp_a.push_back(32'h0000_2000 + 4 * k);
		for (int k = 0; k < 3; k++)
			exp_d.push_back(~(src + 4 * k));
		tc_seen = 0;
		axw(8'h00, 32'h0000_0813);
		idle_wait();
		chk(tc_seen, 1);
		axr(8'h00);
		chk(d[3:0], 4'h8);
		$display("test step done");
		src = $urandom & 32'h00ff_fffc;
		slow <= 1'($urandom);
		axw(8'h14, src);
		axw(8'h1c, 32'h0000_0001);
		exp_a.push_back(src);
		exp_a.push_back(src + 4);
		exp_ch = 4'h2;
		tc_seen = 0;
		axw(8'h10, 32'h0000_0871);
		channel_request_in <= 4'h2;
		idle_wait();
		chk(tc_seen, 1);
		$display("test flyby done");
		src = $urandom & 32'h00ff_fffc;
		slow <= 1'($urandom);
		axw(8'h24, src);
		axw(8'h28, 32'h0000_3000);
		axw(8'h2c, 32'h0000_0001);
		exp_a.push_back(32'h0000_3000);
		exp_d.push_back(~src);
		exp_ch = 4'h4;
		tc_seen = 0;
		axw(8'h20, 32'h0000_0801);
		channel_request_in <= 4'h4;
		for (i = 0; i < 3000 && exp_a.size() != 0; i++)
			@(posedge aclk);
		channel_request_in <= 4'h0;
		lim();
		idle_wait();
		chk(tc_seen, 0);
		dma_stop_in <= 1'b1;
		@(posedge aclk);
		dma_stop_in <= 1'b0;
		axr(8'h40);
		chk(d, 32'h0000_0004);
		axr(8'h20);
		chk(d[0], 1'b0);
		$display("test stop done");
		give_verdict();
	end
endmodule : dma_transfer_mode_control_tb
`default_nettype wire

// file: dtm_arb.sv
`timescale 1ns/1ps
`default_nettype none
module dtm_arb #(
	parameter int NCH = 4,
	parameter int IW = 2
) (
	// Candidates
	input wire logic [NCH-1:0] elig,
	input wire logic [NCH-1:0] pref,
	// Result
	output logic any,
	output logic [IW-1:0] gnt
);
	logic [NCH-1:0] pick;

	always_comb
	begin
		pick = ((elig & pref) != '0) ? (elig & pref) : elig;
		any = (elig != '0);
		gnt = '0;
		for (int i = NCH - 1; i >= 0; i--)
		begin
			if (pick[i])
			begin
				gnt = IW'(i);
			end
		end
	end
endmodule : dtm_arb
`default_nettype wire

// file: dtm_cfg.svh
`ifndef DTM_CFG_SVH
`define DTM_CFG_SVH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define DTM_OFF_CTRL 2'h0
`define DTM_OFF_SRC 2'h1
`define DTM_OFF_DST 2'h2
`define DTM_OFF_CNT 2'h3
`define DTM_OFF_DIS 8'h40
// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define DTM_CTRL_EN 0
`define DTM_CTRL_TRIG 1
`define DTM_CTRL_INIT 2
`define DTM_CTRL_TERM 3
`define DTM_CTRL_MODE_LO 4
`define DTM_CTRL_FLY 6
`define DTM_CTRL_IO2MEM 7
`define DTM_CTRL_SRAM 8
`define DTM_CTRL_DRAM 9
`define DTM_CTRL_SIZE_LO 10
// ----------------------------------------------------------------
// Reset values and encodings
// ----------------------------------------------------------------
`define DTM_RST_WORD 32'h0000_0000
`define DTM_CT_NONE 3'b000
`define DTM_CT_TWO 3'b110
`define DTM_CT_FLY 3'b111
`define DTM_RESP_OKAY 2'b00
`define DTM_RESP_SLVERR 2'b10
// ----------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------
`define DTM_HOLDOFF_CLKS 2'd3
`define DTM_LINE_UNITS 3'd4
`endif

// file: dtm_chbuf.sv
`timescale 1ns/1ps
`default_nettype none
module dtm_chbuf #(
	parameter int AW = 32,
	parameter int CW = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	// Software writes
	input wire logic wr_src,
	input wire logic wr_dst,
	input wire logic wr_cnt,
	input wire logic [31:0] wval,
	// Sequencer control
	input wire logic step,
	input wire logic reload,
	input wire logic [1:0] size,
	// Stages
	output logic [AW-1:0] sh_src,
	output logic [AW-1:0] sh_dst,
	output logic [CW-1:0] sh_cnt,
	output logic [AW-1:0] act_src,
	output logic [AW-1:0] act_dst,
	output logic [CW-1:0] act_cnt
);
	logic fresh_ff;
	logic [AW-1:0] inc;

	assign inc = AW'(1) << size;

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			sh_src <= '0;
			sh_dst <= '0;
			sh_cnt <= '0;
		end
		else if (ce)
		begin
			if (wr_src) sh_src <= wval[AW-1:0];
			if (wr_dst) sh_dst <= wval[AW-1:0];
			if (wr_cnt) sh_cnt <= wval[CW-1:0];
		end
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			fresh_ff <= 1'b1;
			act_src <= '0;
			act_dst <= '0;
			act_cnt <= '0;
		end
		else if (ce)
		begin
			if (reload)
			begin
				fresh_ff <= 1'b1;
				act_src <= sh_src;
				act_dst <= sh_dst;
				act_cnt <= sh_cnt;
			end
			else if (step)
			begin
				fresh_ff <= 1'b0;
				act_src <= act_src + inc;
				act_dst <= act_dst + inc;
				act_cnt <= act_cnt - CW'(1);
			end
			else if (fresh_ff)
			begin
				// Untouched channels follow writes so no reload is needed.
				if (wr_src) act_src <= wval[AW-1:0];
				if (wr_dst) act_dst <= wval[AW-1:0];
				if (wr_cnt) act_cnt <= wval[CW-1:0];
			end
		end
	end
endmodule : dtm_chbuf
`default_nettype wire

// file: dtm_ctrl.sv
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "dtm_cfg.svh"
// Operation
// - Single-step repeats units until terminal count
// - Higher priority served at each release
// - Line mode bursts four units
// - Two-cycle line repeats read-write four times
// - Late lower request served after release
// - Simultaneous requests alternate bursts
// - Block keeps bus until terminal count
// - Block yields only to external master
// - Request sampling resumes three clocks later
// - Active low during RAM side
// - Read, one idle clock, then write
// - Two-cycle type outputs 110
// - Flyby single cycle, memory address source
// - Flyby type 111 with paired strobes
// - Flyby selects I/O by active
// - Enabled request in idle starts transfer
// - Software trigger starts enabled channel
// - Terminal count pulse one clock
// - Stop clears enables, finishes unit, releases
// - Stopped channels keep request, resume later
// - Init bit forcibly terminates channel
// - Stop captures enables into status
// - Address and count two-stage buffers
module dtm_ctrl #(
	parameter int NCH = 4,
	parameter int AW = 32,
	parameter int CW = 16,
	parameter bit FLYBY_OK = 1'b1
) (
	// Clock, reset, enable
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// AXI4-Lite slave
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Requests
	input wire logic [NCH-1:0] channel_request_in,
	input wire logic dma_stop_in,
	// Bus ownership
	output logic bus_req,
	input wire logic bus_grant,
	input wire logic ext_master_req,
	output logic ext_master_ack,
	// System bus
	output logic [AW-1:0] sb_addr,
	output logic sb_rd,
	output logic sb_wr,
	output logic [31:0] system_bus_write_data,
	input wire logic [31:0] system_bus_read_data,
	input wire logic sb_ack,
	output logic [2:0] cycle_type_outputs,
	output logic mem_read_io_write_strobe,
	output logic mem_write_io_read_strobe,
	// Local RAM
	output logic [AW-1:0] ram_addr,
	output logic ram_rd,
	output logic ram_wr,
	output logic [31:0] ram_wdata,
	input wire logic [31:0] ram_rdata,
	// Channel pins
	output logic [NCH-1:0] channel_active_out,
	output logic [NCH-1:0] terminal_count_out
);
	import dtm_pkg::*;
	localparam int IW = 2;
	localparam logic [1:0] LINE_LAST = 2'(`DTM_LINE_UNITS - 3'd1);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	dtm_state_t state_ff, nxt_state;
	dtm_mode_t mode_ff [NCH];
	logic [1:0] size_ff [NCH];
	logic [NCH-1:0] channel_enable_bit_ff, terminal_count_flag_ff;
	logic [NCH-1:0] fly_ff, io2mem_ff, sram_ff, dram_ff;
	logic [NCH-1:0] latch_ff, swt_ff, init_pend_ff, pref_ff, dis_ff;
	logic [NCH-1:0] elig, gnt_oh, ch_oh, above, wr_ctrl, reload, step;
	logic [NCH-1:0] wr_src, wr_dst, wr_cnt, init_apply;
	logic [AW-1:0] sh_src [NCH], sh_dst [NCH], act_src [NCH], act_dst [NCH];
	logic [CW-1:0] sh_cnt [NCH], act_cnt [NCH];
	logic [IW-1:0] ch_ff, gnt;
	logic [1:0] unit_ff, hold_cnt_ff;
	logic stop_pend_ff, win_ff, any, accept, hw_ok, unit_done, last, cut;
	logic rack, wack, cur_fly, src_ram, dst_ram;
	logic aw_got_ff, w_got_ff, do_wr;
	logic [7:0] awaddr_ff;
	logic [31:0] wdata_ff, wmask, wmerge;
	logic [3:0] wstrb_ff;
	logic [31:0] data_ff;
	dtm_mode_t cur_mode;

	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	function automatic logic mapped(input logic [7:0] a);
		return (a[7:6] == 2'b00 && a[1:0] == 2'b00) || a == `DTM_OFF_DIS;
	endfunction : mapped

	function automatic logic [31:0] reg_val(input logic [7:0] a);
		logic [1:0] c;
		logic [31:0] v;
		c = a[5:4];
		v = `DTM_RST_WORD;
		if (a[7:6] == 2'b00)
		begin
			unique case (a[3:2])
				`DTM_OFF_CTRL: v = {20'h0_0000, size_ff[c], dram_ff[c],
					sram_ff[c], io2mem_ff[c], fly_ff[c], mode_ff[c],
					terminal_count_flag_ff[c], 2'b00,
					channel_enable_bit_ff[c]};
				`DTM_OFF_SRC: v = 32'(sh_src[c]);
				`DTM_OFF_DST: v = 32'(sh_dst[c]);
				`DTM_OFF_CNT: v = 32'(sh_cnt[c]);
			endcase
		end
		else if (a == `DTM_OFF_DIS)
		begin
			v = 32'(dis_ff);
		end
		return v;
	endfunction : reg_val

	assign awready = ce && !aw_got_ff && !bvalid;
	assign wready = ce && !w_got_ff && !bvalid;
	assign arready = ce && !rvalid;
	assign do_wr = aw_got_ff && w_got_ff && !bvalid;
	assign wmask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}},
		{8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
	assign wmerge = (reg_val(awaddr_ff) & ~wmask) | (wdata_ff & wmask);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_got_ff <= 1'b0;
			w_got_ff <= 1'b0;
			awaddr_ff <= '0;
			wdata_ff <= '0;
			wstrb_ff <= '0;
			bvalid <= 1'b0;
			bresp <= `DTM_RESP_OKAY;
		end
		else if (ce)
		begin
			if (awvalid && awready)
			begin
				aw_got_ff <= 1'b1;
				awaddr_ff <= awaddr;
			end
			if (wvalid && wready)
			begin
				w_got_ff <= 1'b1;
				wdata_ff <= wdata;
				wstrb_ff <= wstrb;
			end
			if (do_wr)
			begin
				aw_got_ff <= 1'b0;
				w_got_ff <= 1'b0;
				bvalid <= 1'b1;
				bresp <= mapped(awaddr_ff) ? `DTM_RESP_OKAY : `DTM_RESP_SLVERR;
			end
			else if (bvalid && bready)
			begin
				bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid <= 1'b0;
			rdata <= `DTM_RST_WORD;
			rresp <= `DTM_RESP_OKAY;
		end
		else if (ce)
		begin
			if (arvalid && arready)
			begin
				rvalid <= 1'b1;
				rdata <= reg_val(araddr);
				rresp <= mapped(araddr) ? `DTM_RESP_OKAY : `DTM_RESP_SLVERR;
			end
			else if (rvalid && rready)
			begin
				rvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Channel registers
	// ----------------------------------------------------------------
	always_comb
	begin
		for (int n = 0; n < NCH; n++)
		begin
			wr_ctrl[n] = do_wr && awaddr_ff[7:6] == 2'b00
				&& awaddr_ff[5:4] == 2'(n);
			wr_src[n] = wr_ctrl[n] && awaddr_ff[3:2] == `DTM_OFF_SRC;
			wr_dst[n] = wr_ctrl[n] && awaddr_ff[3:2] == `DTM_OFF_DST;
			wr_cnt[n] = wr_ctrl[n] && awaddr_ff[3:2] == `DTM_OFF_CNT;
			wr_ctrl[n] = wr_ctrl[n] && awaddr_ff[3:2] == `DTM_OFF_CTRL;
			// Init acts when channel not on the bus
			init_apply[n] = init_pend_ff[n]
				&& !(state_ff != ST_IDLE && ch_ff == IW'(n));
			step[n] = unit_done && ch_ff == IW'(n);
			reload[n] = (step[n] && last) || init_apply[n];
			elig[n] = channel_enable_bit_ff[n] && !terminal_count_flag_ff[n]
				&& !init_pend_ff[n] && ((hw_ok && channel_request_in[n])
				|| swt_ff[n] || latch_ff[n]);
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			fly_ff <= '0;
			io2mem_ff <= '0;
			sram_ff <= '0;
			dram_ff <= '0;
			for (int n = 0; n < NCH; n++)
			begin
				mode_ff[n] <= MD_SINGLE;
				size_ff[n] <= 2'b00;
			end
		end
		else if (ce)
		begin
			for (int n = 0; n < NCH; n++)
			begin
				if (wr_ctrl[n])
				begin
					mode_ff[n] <= dtm_mode_t'(wmerge[`DTM_CTRL_MODE_LO +: 2]);
					size_ff[n] <= wmerge[`DTM_CTRL_SIZE_LO +: 2];
					// Flyby only with a capable controller
					fly_ff[n] <= wmerge[`DTM_CTRL_FLY] && FLYBY_OK;
					io2mem_ff[n] <= wmerge[`DTM_CTRL_IO2MEM];
					sram_ff[n] <= wmerge[`DTM_CTRL_SRAM];
					dram_ff[n] <= wmerge[`DTM_CTRL_DRAM];
				end
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			channel_enable_bit_ff <= '0;
			terminal_count_flag_ff <= '0;
			swt_ff <= '0;
			init_pend_ff <= '0;
		end
		else if (ce)
		begin
			for (int n = 0; n < NCH; n++)
			begin
				if (dma_stop_in || reload[n])
					channel_enable_bit_ff[n] <= 1'b0;
				else if (wr_ctrl[n])
					channel_enable_bit_ff[n] <= wmerge[`DTM_CTRL_EN];
				if (init_apply[n] || (wr_ctrl[n] && wmerge[`DTM_CTRL_EN]))
					terminal_count_flag_ff[n] <= 1'b0;
				if (step[n] && last)
					terminal_count_flag_ff[n] <= 1'b1;
				if ((accept && gnt == IW'(n)) || init_apply[n])
					swt_ff[n] <= 1'b0;
				if (wr_ctrl[n] && wmerge[`DTM_CTRL_TRIG] && wmerge[`DTM_CTRL_EN])
					swt_ff[n] <= 1'b1;
				if (init_apply[n])
					init_pend_ff[n] <= 1'b0;
				if (wr_ctrl[n] && wmerge[`DTM_CTRL_INIT])
					init_pend_ff[n] <= 1'b1;
			end
		end
	end

	// Held request keeps the channel going
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			latch_ff <= '0;
		else if (ce)
		begin
			for (int n = 0; n < NCH; n++)
			begin
				if (reload[n] || (state_ff == ST_DONE && ch_ff == IW'(n)
					&& mode_ff[n] == MD_LINE && !stop_pend_ff))
					latch_ff[n] <= 1'b0;
				else if (accept && gnt == IW'(n) && mode_ff[n] != MD_SINGLE)
					latch_ff[n] <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			dis_ff <= '0;
		else if (ce && dma_stop_in)
			dis_ff <= channel_enable_bit_ff;
	end

	genvar gi;
	generate
		for (gi = 0; gi < NCH; gi++)
		begin : g_buf
			dtm_chbuf #(.AW(AW), .CW(CW)) u_buf (
				.clk(aclk), .resetn(aresetn), .ce(ce),
				.wr_src(wr_src[gi]), .wr_dst(wr_dst[gi]), .wr_cnt(wr_cnt[gi]),
				.wval(wmerge), .step(step[gi]), .reload(reload[gi]),
				.size(size_ff[gi]), .sh_src(sh_src[gi]), .sh_dst(sh_dst[gi]),
				.sh_cnt(sh_cnt[gi]), .act_src(act_src[gi]),
				.act_dst(act_dst[gi]), .act_cnt(act_cnt[gi])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Arbitration
	// ----------------------------------------------------------------
	// Arbitration at every release
	dtm_arb #(.NCH(NCH), .IW(IW)) u_arb (
		.elig(elig),
		.pref(pref_ff),
		.any(any),
		.gnt(gnt)
	);

	assign accept = state_ff == ST_IDLE && any;
	assign gnt_oh = NCH'(1) << gnt;
	assign ch_oh = NCH'(1) << ch_ff;
	assign above = ~((ch_oh << 1) - NCH'(1));
	// Hardware requests wait out the hold-off
	assign hw_ok = hold_cnt_ff == 2'd0;

	// Late lower request gains the next slot
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			win_ff <= 1'b0;
			pref_ff <= '0;
		end
		else if (ce)
		begin
			win_ff <= state_ff == ST_DONE;
			if (state_ff == ST_DONE || win_ff)
				pref_ff <= (pref_ff & ~(accept ? gnt_oh : '0))
					| (channel_request_in & above & channel_enable_bit_ff);
			else if (accept)
				pref_ff <= pref_ff & ~gnt_oh;
		end
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	assign cur_mode = mode_ff[ch_ff];
	assign cur_fly = fly_ff[ch_ff];
	assign src_ram = sram_ff[ch_ff];
	assign dst_ram = dram_ff[ch_ff];
	assign last = act_cnt[ch_ff] == '0;
	assign cut = stop_pend_ff || init_pend_ff[ch_ff];
	// RAM answers in one clock, so its side never waits.
	assign rack = src_ram || sb_ack;
	assign wack = dst_ram || sb_ack;
	assign unit_done = (state_ff == ST_WR_W && wack)
		|| (state_ff == ST_FLY_W && sb_ack);
	// Only an outside master may take the bus
	assign ext_master_ack = ext_master_req
		&& (state_ff == ST_IDLE || state_ff == ST_READY);

	always_comb
	begin
		nxt_state = state_ff;
		unique case (state_ff)
			ST_IDLE: if (any) nxt_state = ST_READY;
			ST_READY:
				if (cut)
					nxt_state = ST_DONE;
				else if (bus_grant && !ext_master_req)
					nxt_state = cur_fly ? ST_FLY : ST_RD;
			ST_RD: nxt_state = ST_RD_W;
			// One idle clock between read and write
			ST_RD_W: if (rack) nxt_state = ST_GAP;
			ST_GAP: nxt_state = ST_WR;
			ST_WR: nxt_state = ST_WR_W;
			ST_FLY: nxt_state = ST_FLY_W;
			ST_WR_W, ST_FLY_W:
				if (unit_done)
				begin
					if (last || cut)
						nxt_state = ST_DONE;
					else if (cur_mode == MD_BLOCK)
						nxt_state = ST_READY;
					else if (cur_mode == MD_LINE && unit_ff != LINE_LAST)
						nxt_state = ST_READY;
					else
						nxt_state = ST_DONE;
				end
			ST_DONE: nxt_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_ff <= ST_IDLE;
			ch_ff <= '0;
			unit_ff <= 2'd0;
			hold_cnt_ff <= 2'd0;
			stop_pend_ff <= 1'b0;
			data_ff <= `DTM_RST_WORD;
		end
		else if (ce)
		begin
			state_ff <= nxt_state;
			if (accept)
			begin
				ch_ff <= gnt;
				unit_ff <= 2'd0;
			end
			else if (unit_done)
				unit_ff <= unit_ff + 2'd1;
			if (unit_done)
				hold_cnt_ff <= `DTM_HOLDOFF_CLKS - 2'd1;
			else if (hold_cnt_ff != 2'd0)
				hold_cnt_ff <= hold_cnt_ff - 2'd1;
			if (state_ff == ST_IDLE || state_ff == ST_DONE)
				stop_pend_ff <= 1'b0;
			else if (dma_stop_in)
				stop_pend_ff <= 1'b1;
			if (state_ff == ST_RD_W && rack)
				data_ff <= src_ram ? ram_rdata : system_bus_read_data;
		end
	end

	// ----------------------------------------------------------------
	// Bus outputs
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bus_req <= 1'b0;
			sb_addr <= '0;
			sb_rd <= 1'b0;
			sb_wr <= 1'b0;
			system_bus_write_data <= `DTM_RST_WORD;
			cycle_type_outputs <= `DTM_CT_NONE;
			mem_read_io_write_strobe <= 1'b0;
			mem_write_io_read_strobe <= 1'b0;
			ram_addr <= '0;
			ram_rd <= 1'b0;
			ram_wr <= 1'b0;
			ram_wdata <= `DTM_RST_WORD;
			channel_active_out <= '0;
			terminal_count_out <= '0;
		end
		else if (ce)
		begin
			bus_req <= nxt_state != ST_IDLE && nxt_state != ST_DONE;
			sb_rd <= (nxt_state == ST_RD || nxt_state == ST_RD_W) && !src_ram;
			sb_wr <= (nxt_state == ST_WR || nxt_state == ST_WR_W) && !dst_ram;
			// Memory address from the destination stage during write, otherwise from the source stage
			sb_addr <= (nxt_state == ST_WR || nxt_state == ST_WR_W)
				? act_dst[ch_ff] : act_src[ch_ff];
			system_bus_write_data <= data_ff;
			ram_addr <= (nxt_state == ST_WR) ? act_dst[ch_ff] : act_src[ch_ff];
			ram_rd <= nxt_state == ST_RD && src_ram;
			ram_wr <= nxt_state == ST_WR && dst_ram;
			ram_wdata <= data_ff;
			if (nxt_state == ST_FLY || nxt_state == ST_FLY_W)
				cycle_type_outputs <= `DTM_CT_FLY;
			else if (nxt_state inside {ST_RD, ST_RD_W, ST_GAP, ST_WR, ST_WR_W})
				cycle_type_outputs <= `DTM_CT_TWO;
			else
				cycle_type_outputs <= `DTM_CT_NONE;
			mem_read_io_write_strobe <= (nxt_state == ST_FLY
				|| nxt_state == ST_FLY_W) && !io2mem_ff[ch_ff];
			mem_write_io_read_strobe <= (nxt_state == ST_FLY
				|| nxt_state == ST_FLY_W) && io2mem_ff[ch_ff];
			// Active only on the memory side
			channel_active_out <= ((nxt_state inside {ST_FLY, ST_FLY_W})
				|| ((nxt_state inside {ST_RD, ST_RD_W}) && !src_ram)
				|| ((nxt_state inside {ST_WR, ST_WR_W}) && !dst_ram))
				? ch_oh : '0;
			// Pulse at the final write or flyby start
			terminal_count_out <= (nxt_state != state_ff && last
				&& (nxt_state == ST_WR || nxt_state == ST_FLY)) ? ch_oh : '0;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn || !ce);

	sequence s_gap_write;
		##1 (state_ff == ST_GAP) ##1 (state_ff == ST_WR);
	endsequence
	property p_gap;
		(state_ff == ST_RD_W && rack && ce) |-> s_gap_write;
	endproperty
	a_gap: assert property (p_gap) else $error("no single idle clock");
	property p_type_two;
		(state_ff == ST_WR) |-> cycle_type_outputs == `DTM_CT_TWO;
	endproperty
	a_type_two: assert property (p_type_two) else $error("bad two-cycle type");
	property p_type_fly;
		(state_ff == ST_FLY) |-> cycle_type_outputs == `DTM_CT_FLY
			&& (mem_read_io_write_strobe != mem_write_io_read_strobe);
	endproperty
	a_type_fly: assert property (p_type_fly) else $error("bad flyby type");
	property p_tc_pulse;
		(terminal_count_out != '0) |=> terminal_count_out == '0;
	endproperty
	a_tc_pulse: assert property (p_tc_pulse) else $error("tc longer than one clock");
	property p_holdoff;
		(unit_done ##1 !unit_done [*2]) |=> hw_ok;
	endproperty
	a_holdoff: assert property (p_holdoff) else $error("sampling not resumed");
	property p_holdoff_early;
		unit_done |=> !hw_ok ##1 !hw_ok;
	endproperty
	a_holdoff_early: assert property (p_holdoff_early) else $error("sampling too early");
	property p_stop;
		dma_stop_in |=> channel_enable_bit_ff == '0 && dis_ff == $past(channel_enable_bit_ff);
	endproperty
	a_stop: assert property (p_stop) else $error("stop did not clear enables");
	property p_line;
		(unit_done && cur_mode == MD_LINE && unit_ff != LINE_LAST && !last && !cut)
			|=> state_ff == ST_READY;
	endproperty
	a_line: assert property (p_line) else $error("line burst cut short");
	property p_ram_inactive;
		(state_ff == ST_RD_W && src_ram) |-> channel_active_out == '0;
	endproperty
	a_ram_inactive: assert property (p_ram_inactive) else $error("active during RAM");
	property p_term_flag;
		(unit_done && last) |=> terminal_count_flag_ff[$past(ch_ff)];
	endproperty
	a_term_flag: assert property (p_term_flag) else $error("terminal flag not set");
endmodule : dtm_ctrl
`default_nettype wire

// file: dtm_mem.sv
`timescale 1ns/1ps
`default_nettype none
module dtm_mem (
	// Bus side
	input wire logic aclk,
	input wire logic slow,
	input wire logic bus_req,
	input wire logic [3:0] cyc,
	input wire logic [31:0] sb_addr,
	output logic bus_grant,
	output logic sb_ack,
	output logic [31:0] rd_data
);
	int held = 0;
	logic [31:0] last = 32'h0000_0000;
	assign bus_grant = bus_req;
	// Flyby capable, one ack per cycle
	assign sb_ack = cyc != 4'h0 && held >= (slow ? 3 : 1);
	always_ff @(posedge aclk)
	begin
		held <= (sb_ack || cyc == 4'h0) ? 0 : held + 1;
		if (cyc[3])
			last <= ~sb_addr;
	end
	// Released lines show the last read address uninverted, so stale data cannot match.
	assign rd_data = cyc[3] ? ~sb_addr : ~last;
endmodule : dtm_mem
`default_nettype wire

// file: dtm_pkg.sv
package dtm_pkg;
	typedef enum logic [1:0] {MD_SINGLE, MD_STEP, MD_LINE, MD_BLOCK} dtm_mode_t;
	typedef enum logic [3:0] {
		ST_IDLE, ST_READY, ST_RD, ST_RD_W, ST_GAP,
		ST_WR, ST_WR_W, ST_FLY, ST_FLY_W, ST_DONE
	} dtm_state_t;
endpackage : dtm_pkg
